//--- verilog/reset_state_manager_pkg.sv
// Constants and types for the reset state manager.
// Assumes an AHB-Lite fabric with 32-bit data and one word per register.
package reset_state_manager_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] WRITE_KEY = 8'hA5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int KEY_LSB = 24;
	localparam int CMD_CPU_BIT = 0;
	localparam int CMD_PERIPH_BIT = 2;
	localparam int CMD_PIN_BIT = 3;
	localparam int ST_SEEN_BIT = 0;
	localparam int ST_CAUSE_LSB = 8;
	localparam int ST_LEVEL_BIT = 16;
	localparam int ST_BUSY_BIT = 17;
	localparam int MODE_URE_BIT = 0;
	localparam int MODE_UIE_BIT = 4;
	localparam int MODE_LEN_LSB = 8;

	// ------------------------------------------------------------
	// Reset causes and timing
	// ------------------------------------------------------------
	localparam logic [2:0] CAUSE_GENERAL = 3'h0;
	localparam logic [2:0] CAUSE_WAKEUP = 3'h1;
	localparam logic [2:0] CAUSE_WDOG = 3'h2;
	localparam logic [2:0] CAUSE_SW = 3'h3;
	localparam logic [2:0] CAUSE_USER = 3'h4;
	localparam logic [1:0] STATE_CYCLES = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_USER = 5'b00010,
		ST_START = 5'b00100,
		ST_SOFT = 5'b01000,
		ST_WDOG = 5'b10000
	} rsm_state_t;

endpackage

//--- verilog/reset_state_manager.sv
// Reset state manager: pin reset, software commands, watchdog reset.
// Assumes slow_clock and the pin are synchronous to mclk; slow clock
// rising edges are found by sampling it on mclk.
`timescale 1ns/1ps
module reset_state_manager
	import reset_state_manager_pkg::*;
	#(
		parameter int PULSE_W = 17
	)
	(
		// Clock and reset
		input wire logic mclk,
		input wire logic rst,
		// AHB-Lite slave
		input wire logic hsel,
		input wire logic [31:0] haddr,
		input wire logic [1:0] htrans,
		input wire logic hwrite,
		input wire logic [2:0] hsize,
		input wire logic [31:0] hwdata,
		input wire logic hready,
		output logic hreadyout,
		output logic hresp,
		output logic [31:0] hrdata,
		// Slow clock and power strap
		input wire logic slow_clock,
		input wire logic backup_power_rise,
		// Watchdog
		input wire logic wdog_fault,
		input wire logic wdog_reset_enable,
		input wire logic wdog_cpu_only,
		// External reset pin, open drain
		input wire logic pin_in,
		output logic pin_out,
		output logic pin_oe,
		// Internal resets and interrupt
		output logic cpu_reset,
		output logic periph_reset,
		output logic cpu_clk_en,
		output logic user_reset_irq
	);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	rsm_state_t state_q, state_d;
	logic [1:0] cnt_q, cnt_d;
	logic slow_prev_q;
	logic pin_s1_q, pin_s2_q;
	logic pin_level_q;
	logic seen_q;
	logic busy_q;
	logic cmd_cpu_q, cmd_per_q, cmd_pin_q;
	logic wd_pend_q;
	logic self_q;
	logic init_q;
	logic [2:0] cause_q;
	logic ure_q, uie_q;
	logic [3:0] len_q;
	logic [PULSE_W-1:0] pulse_q, pulse_d;
	logic wr_q, rd_unused_q;
	logic [7:0] addr_q;
	logic cpu_reset_q, periph_reset_q, clk_en_q, pin_oe_q, irq_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire logic addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
	wire logic rd_take = addr_phase && !hwrite;
	wire logic wr_take = addr_phase && hwrite;
	wire logic [7:0] word_ofs = {haddr[7:2], 2'b00};
	wire logic ofs_hit = haddr[31:8] == 24'h000000;
	wire logic rd_status = rd_take && ofs_hit && word_ofs == OFS_STATUS;
	wire logic key_ok = hwdata[KEY_LSB +: 8] == WRITE_KEY;
	wire logic wr_mode = wr_q && addr_q == OFS_MODE && key_ok;
	wire logic [2:0] cmd_bits =
		{hwdata[CMD_PIN_BIT], hwdata[CMD_PERIPH_BIT], hwdata[CMD_CPU_BIT]};
	wire logic cmd_ok = wr_q && addr_q == OFS_COMMAND && key_ok;
	// Locked while busy or while another reset holds the processor
	wire logic cmd_take = cmd_ok && (cmd_bits != 3'h0) && !busy_q
		&& state_q == ST_IDLE
		&& !(wd_pend_q && wdog_reset_enable);

	// ------------------------------------------------------------
	// Slow clock tick and pin resynchronisation
	// ------------------------------------------------------------
	wire logic tick = slow_clock && !slow_prev_q;
	wire logic pin_high = pin_s2_q;
	wire logic pulse_busy = pulse_q != '0;
	wire logic wd_req = wd_pend_q && wdog_reset_enable;
	wire logic user_req = ure_q && !pin_high && !self_q;
	wire logic ext_hold = self_q && !pulse_busy && !pin_high;
	wire logic cnt_done = cnt_q == 2'h0;
	wire logic [PULSE_W-1:0] pulse_len =
		PULSE_W'(1) << (5'(len_q) + 5'h1);
	wire logic pin_falling = pin_level_q && !pin_in;

	// ------------------------------------------------------------
	// State machine on slow clock ticks
	// ------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (wd_req)
				begin
					state_d = ST_WDOG;
					cnt_d = STATE_CYCLES - 2'h1;
				end
				else if (busy_q)
				begin
					state_d = ST_SOFT;
					cnt_d = STATE_CYCLES - 2'h1;
				end
				else if (user_req)
					state_d = ST_USER;
			end
			ST_USER:
			begin
				if (pin_high)
				begin
					state_d = ST_START;
					cnt_d = STATE_CYCLES - 2'h1;
				end
			end
			ST_START:
			begin
				if (cnt_done)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - 2'h1;
			end
			ST_SOFT:
			begin
				if (wd_req)
				begin
					state_d = ST_WDOG;
					cnt_d = STATE_CYCLES - 2'h1;
				end
				else if (cnt_done && !ext_hold)
					state_d = ST_IDLE;
				else if (!cnt_done)
					cnt_d = cnt_q - 2'h1;
			end
			ST_WDOG:
			begin
				if (cnt_done && !ext_hold)
					state_d = ST_IDLE;
				else if (!cnt_done)
					cnt_d = cnt_q - 2'h1;
			end
		endcase
	end

	wire logic enter_wdog = state_q != ST_WDOG && state_d == ST_WDOG;
	wire logic enter_soft = state_q == ST_IDLE && state_d == ST_SOFT;
	wire logic leave_soft = state_q == ST_SOFT && state_d == ST_IDLE;
	wire logic leave_any = state_q != ST_IDLE && state_d == ST_IDLE;
	wire logic pulse_start = (enter_soft && cmd_pin_q)
		|| (enter_wdog && !wdog_cpu_only);

	always_comb
	begin
		pulse_d = pulse_q;
		if (pulse_start)
			pulse_d = pulse_len;
		else if (pulse_busy)
			pulse_d = pulse_q - PULSE_W'(1);
	end

	// Reset levels for the state being entered; reset cause from the state being left
	wire logic [2:0] cause_next =
		state_q == ST_START ? CAUSE_USER :
		state_q == ST_WDOG ? CAUSE_WDOG : CAUSE_SW;
	wire logic cause_load = tick && leave_any
		&& (state_q != ST_SOFT || cmd_cpu_q);
	wire logic cpu_next = state_d != ST_IDLE
		&& (state_d != ST_SOFT || cmd_cpu_q);
	wire logic per_next = state_d == ST_USER || state_d == ST_START
		|| (state_d == ST_SOFT && cmd_per_q)
		|| (state_d == ST_WDOG && (state_q == ST_WDOG
			? periph_reset_q : !wdog_cpu_only));
	// Tick levels, or the held level between ticks
	wire logic cpu_hold = tick ? cpu_next : cpu_reset_q;
	wire logic per_hold = tick ? per_next : periph_reset_q;

	// ------------------------------------------------------------
	// Slow-clock sequencing registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			slow_prev_q <= 1'b0;
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			state_q <= ST_IDLE;
			cnt_q <= 2'h0;
			pulse_q <= '0;
			self_q <= 1'b0;
		end
		else
		begin
			slow_prev_q <= slow_clock;
			if (tick)
			begin
				pin_s1_q <= pin_in;
				pin_s2_q <= pin_s1_q;
				state_q <= state_d;
				cnt_q <= cnt_d;
				pulse_q <= pulse_d;
				if (pulse_start)
					self_q <= 1'b1;
				else if (!pulse_busy && pin_high)
					self_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Command, watchdog and reset outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			busy_q <= 1'b0;
			cmd_cpu_q <= 1'b0;
			cmd_per_q <= 1'b0;
			cmd_pin_q <= 1'b0;
			wd_pend_q <= 1'b0;
			cpu_reset_q <= 1'b0;
			periph_reset_q <= 1'b0;
			clk_en_q <= 1'b1;
			pin_oe_q <= 1'b0;
		end
		else
		begin
			if (cmd_take)
			begin
				busy_q <= 1'b1;
				cmd_cpu_q <= cmd_bits[0];
				cmd_per_q <= cmd_bits[1];
				cmd_pin_q <= cmd_bits[2];
			end
			else if (tick && (leave_soft || enter_wdog))
				busy_q <= 1'b0;
			// Fault held until the next slow clock tick, then consumed
			if (wdog_fault)
				wd_pend_q <= 1'b1;
			else if (tick)
				wd_pend_q <= 1'b0;
			// Command on a tick edge must not skip the tick update
			cpu_reset_q <= cpu_hold || (cmd_take && cmd_bits[0]);
			periph_reset_q <= per_hold || (cmd_take && cmd_bits[1]);
			if (tick)
			begin
				clk_en_q <= state_d != ST_USER;
				pin_oe_q <= pulse_d != '0;
			end
		end
	end

	// ------------------------------------------------------------
	// Status, mode and cause
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pin_level_q <= 1'b1;
			seen_q <= 1'b0;
			irq_q <= 1'b0;
			init_q <= 1'b0;
			cause_q <= CAUSE_GENERAL;
			ure_q <= 1'b0;
			uie_q <= 1'b0;
			len_q <= 4'h0;
		end
		else
		begin
			pin_level_q <= pin_in;
			// Set wins over the read clear
			if (pin_falling)
				seen_q <= 1'b1;
			else if (rd_status)
				seen_q <= 1'b0;
			irq_q <= !ure_q && uie_q
				&& (pin_falling || (seen_q && !rd_status));
			init_q <= 1'b1;
			if (!init_q)
				cause_q <= backup_power_rise ? CAUSE_GENERAL : CAUSE_WAKEUP;
			else if (cause_load)
				cause_q <= cause_next;
			if (wr_mode)
			begin
				ure_q <= hwdata[MODE_URE_BIT];
				uie_q <= hwdata[MODE_UIE_BIT];
				len_q <= hwdata[MODE_LEN_LSB +: 4];
			end
		end
	end

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	wire logic [31:0] status_word = {31'h0, seen_q} << ST_SEEN_BIT
		| {29'h0, cause_q} << ST_CAUSE_LSB
		| {31'h0, pin_level_q} << ST_LEVEL_BIT
		| {31'h0, busy_q} << ST_BUSY_BIT;
	wire logic [31:0] mode_word = {31'h0, ure_q} << MODE_URE_BIT
		| {31'h0, uie_q} << MODE_UIE_BIT
		| {28'h0, len_q} << MODE_LEN_LSB;
	wire logic [31:0] read_word = !ofs_hit ? 32'h0 :
		word_ofs == OFS_STATUS ? status_word :
		word_ofs == OFS_MODE ? mode_word : 32'h0;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= 1'b0;
			rd_unused_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata_q <= 32'h0;
			hreadyout_q <= 1'b0;
		end
		else
		begin
			hreadyout_q <= 1'b1;
			wr_q <= wr_take && ofs_hit;
			rd_unused_q <= hsize != 3'h2;
			addr_q <= word_ofs;
			if (rd_take)
				hrdata_q <= read_word;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0 & rd_unused_q;
	assign hrdata = hrdata_q;
	assign pin_out = 1'b0;
	assign pin_oe = pin_oe_q;
	assign cpu_reset = cpu_reset_q;
	assign periph_reset = periph_reset_q;
	assign cpu_clk_en = clk_en_q;
	assign user_reset_irq = irq_q;

endmodule // reset_state_manager

//--- test/reset_state_manager_checker.sv
// Checker: reset outputs, pin pulse and bus effects of the manager.
// Assumes a slow clock synchronous to mclk and one bus master.
`timescale 1ns/1ps
module reset_state_manager_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Bus
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Pin, resets and interrupt
	input wire logic slow_clock,
	input wire logic pin_in,
	input wire logic pin_oe,
	input wire logic cpu_reset,
	input wire logic periph_reset,
	input wire logic cpu_clk_en,
	input wire logic user_reset_irq
);
	logic sc_q;
	logic wc_q;
	logic rs_q;
	logic [3:0] ct_q;
	logic [3:0] pt_q;
	wire logic tick = slow_clock && !sc_q;
	wire logic req = htrans == 2'h2 && hready;
	wire logic good = hwdata[31:24] == 8'hA5;
	wire logic quiet = !cpu_reset && !periph_reset && !pin_oe && pin_in;
	wire logic [3:0] ct_d = cpu_reset ? ct_q + {3'h0, tick} : 4'h0;
	wire logic [3:0] pt_d = pin_oe ? pt_q + {3'h0, tick} : 4'h0;

	// --------------------------------------------------------------
	// Tick counts while the CPU reset or pin drive is held
	// --------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			sc_q <= 1'b0;
			wc_q <= 1'b0;
			rs_q <= 1'b0;
			ct_q <= 4'h0;
			pt_q <= 4'h0;
		end
		else
		begin
			sc_q <= slow_clock;
			wc_q <= req && hwrite && haddr == 32'h0;
			rs_q <= req && !hwrite && haddr == 32'h4;
			ct_q <= ct_d == 4'h0 && cpu_reset ? ct_q : ct_d;
			pt_q <= pt_d == 4'h0 && pin_oe ? pt_q : pt_d;
		end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence clk_back_s;
		$rose(cpu_clk_en) ##0 cpu_reset;
	endsequence

	user_hold_a: assert property (!cpu_clk_en |-> cpu_reset && periph_reset)
		else $error("user reset without both resets");
	clk_first_a: assert property ($rose(cpu_clk_en) |-> cpu_reset)
		else $error("clock back after reset release");
	start_bound_a: assert property (clk_back_s |-> ##[1:40] !cpu_reset)
		else $error("startup too long");
	soft_len_a: assert property ($fell(cpu_reset) |-> ct_q >= 4'h3)
		else $error("reset shorter than three ticks");
	pulse_len_a: assert property ($fell(pin_oe) |-> pt_q >= 4'h2)
		else $error("pin pulse too short");
	irq_clk_a: assert property (user_reset_irq |-> cpu_clk_en)
		else $error("interrupt during user reset");
	irq_clear_a: assert property (rs_q && pin_in && $past(pin_in) |=> !user_reset_irq)
		else $error("interrupt kept after status read");
	cmd_go_a: assert property (wc_q && good && hwdata[0] && quiet |=> cpu_reset)
		else $error("cpu command did not reset");
	cmd_key_a: assert property (wc_q && !good && quiet |=> !cpu_reset && !periph_reset)
		else $error("bad key command acted");
endmodule // reset_state_manager_checker

bind reset_state_manager reset_state_manager_checker i_chk (.*);

//--- test/reset_line_model.sv
// Partner: the board reset line with its pull-up and an outside device.
// Assumes the device sinks the line only while pin_oe is high.
`timescale 1ns/1ps
module reset_line_model (
	// Device side
	input wire logic pin_out,
	input wire logic pin_oe,
	// Outside device sinking the line
	input wire logic hold,
	output logic pin_in
);
	// Pull-up wins unless some party sinks the line
	assign pin_in = !((pin_oe && !pin_out) || hold);
endmodule // reset_line_model

//--- test/reset_state_manager_test.sv
// Testbench: register, command, pin and watchdog scenarios.
// Assumes the checker binds itself and the line model acts as board.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module reset_state_manager_test
	import reset_state_manager_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] r;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] sdiv = 3'h0;
	logic backup_power_rise = 1'b0;
	logic wdog_fault = 1'b0;
	logic wdog_reset_enable = 1'b0;
	logic wdog_cpu_only = 1'b0;
	logic hold = 1'b0;
	wire logic slow_clock = sdiv[2];
	wire logic hreadyout, hresp, pin_in, pin_out, pin_oe;
	wire logic cpu_reset, periph_reset, cpu_clk_en, user_reset_irq;
	wire logic [31:0] hrdata;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	int n;

	reset_state_manager i_dut (.*, .hsel(1'b1), .hsize(3'h2),
		.hready(hreadyout));
	reset_line_model i_line (.*);

	always #10 mclk = ~mclk;
	always @(posedge mclk)
	begin
		sdiv <= sdiv + 3'h1;
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end

	// --------------------------------------------------------------
	// Bus and run control
	// --------------------------------------------------------------
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge mclk);
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [31:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic reboot(input logic b);
		@(posedge mclk);
		rst <= 1'b1;
		backup_power_rise <= b;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic results;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_regs;
		reboot(1'b1);
		rd(32'h4);
		`CHK(r, 32'h0001_0000)
		reboot(1'b0);
		wr(32'h4, 32'hFFFF_FFFF);
		wr(32'h8, 32'h5A00_0F11);
		rd(32'h4);
		`CHK(r, 32'h0001_0100)
		for (int i = 0; i < 3; i++)
		begin
			rd(32'(i * 8));
			`CHK(r, 32'h0)
		end
		wr(32'h8, 32'hA500_0F11);
		rd(32'h8);
		`CHK(r, 32'h0000_0F11)
		$display("register test done");
	endtask
	task automatic t_soft;
		wr(32'h8, 32'hA500_0101);
		wr(32'h0, 32'hA500_0009);
		wr(32'h0, 32'hA500_0004);
		@(negedge mclk);
		`CHK({cpu_reset, periph_reset}, 2'b10)
		rd(32'h4);
		`CHK(r[17], 1'b1)
		while (cpu_reset || !pin_in) @(posedge mclk);
		repeat (64) @(posedge mclk);
		rd(32'h4);
		`CHK(r, 32'h0001_0301)
		$display("software reset test done");
	endtask
	task automatic t_cmd;
		wr(32'h0, 32'h5A00_0001);
		@(negedge mclk);
		`CHK({cpu_reset, periph_reset}, 2'b00)
		wr(32'h0, 32'hA500_000C);
		@(negedge mclk);
		`CHK({cpu_reset, periph_reset}, 2'b01)
		n = 0;
		while (!pin_oe) @(posedge mclk);
		while (pin_oe)
		begin
			@(posedge mclk);
			n++;
		end
		`CHK(n, 32)
		while (periph_reset || !pin_in) @(posedge mclk);
		repeat (64) @(posedge mclk);
		rd(32'h4);
		`CHK(r, 32'h0001_0301)
		$display("command test done");
	endtask
	task automatic t_user;
		hold <= 1'b1;
		repeat (60) @(posedge mclk);
		@(negedge mclk);
		`CHK({cpu_reset, periph_reset, cpu_clk_en}, 3'b110)
		@(posedge mclk);
		hold <= 1'b0;
		while (cpu_reset) @(posedge mclk);
		rd(32'h4);
		`CHK(r, 32'h0001_0401)
		rd(32'h4);
		`CHK(r, 32'h0001_0400)
		$display("user reset test done");
	endtask
	task automatic t_irq;
		wr(32'h8, 32'hA500_0010);
		hold <= 1'b1;
		repeat (3) @(negedge mclk);
		`CHK({user_reset_irq, cpu_reset}, 2'b10)
		rd(32'h4);
		`CHK(r[16], 1'b0)
		`CHK(r[0], 1'b1)
		hold <= 1'b0;
		repeat (2) @(negedge mclk);
		`CHK(user_reset_irq, 1'b0)
		// Short low glitch, then read with the line high
		@(posedge mclk);
		hold <= 1'b1;
		@(posedge mclk);
		hold <= 1'b0;
		repeat (3) @(negedge mclk);
		`CHK(user_reset_irq, 1'b1)
		rd(32'h4);
		repeat (2) @(negedge mclk);
		`CHK(user_reset_irq, 1'b0)
		$display("interrupt test done");
	endtask
	task automatic t_wdog(input logic en, only, cmd, input logic [2:0] c);
		logic [3:0] s;
		s = 4'h0;
		if (cmd)
			wr(32'h0, 32'hA500_0001);
		wdog_reset_enable <= en;
		wdog_cpu_only <= only;
		wdog_fault <= 1'b1;
		@(posedge mclk);
		wdog_fault <= 1'b0;
		repeat (160)
		begin
			@(posedge mclk);
			s |= {cpu_reset, periph_reset, pin_oe, !cpu_clk_en};
		end
		`CHK(s, {en | cmd, en & !only, en & !only, 1'b0})
		rd(32'h4);
		`CHK(r[10:8], c)
		$display("watchdog case done");
	endtask

	initial
	begin
		t_regs();
		t_soft();
		t_cmd();
		t_user();
		t_irq();
		wr(32'h8, 32'hA500_0101);
		t_wdog(1'b0, 1'b0, 1'b0, 3'h4);
		t_wdog(1'b1, 1'b1, 1'b1, 3'h2);
		t_wdog(1'b1, 1'b0, 1'b0, 3'h2);
		results();
	end
endmodule // reset_state_manager_test
